// *** inc/nsu_pkg.sv ***
// Purpose: Constants and types shared by the nibble subtract unit.
// Assumes: Register port with 4-bit word index and 16-bit data.
// Notes:   Opcodes sit in the top five bits of a 16-bit instruction.
//
// Function
// - Opcode 10001: memory minus immediate, stored to memory unless comparing.
// - Opcode 00011: register minus memory minus carry, stored to register.
// - Opcode 10011: memory minus immediate minus carry, stored to memory.
// - Compare set: destination untouched, only carry, zero and the status register change.
// - Carry set on borrow, cleared when no borrow.
// - Nonzero result always clears zero flag.
// - Zero result with compare clear sets zero flag.
// - Zero result with compare set keeps zero flag.
// - Decimal mode flag selects binary or decimal-adjusted subtraction.
// - Index enable ORs index register into instruction memory address.
// - Borrow forms consume previous carry for multi-nibble differences.
// - General register is nibble in row chosen by register pointer.
package nsu_pkg;

  localparam int MEM_AW    = 8;
  localparam int MEM_DEPTH = 256;

  // Register word indices
  localparam logic [3:0] OFS_PSW    = 4'h0;
  localparam logic [3:0] OFS_INDEX  = 4'h1;
  localparam logic [3:0] OFS_RPTR   = 4'h2;
  localparam logic [3:0] OFS_MADDR  = 4'h3;
  localparam logic [3:0] OFS_MDATA  = 4'h4;
  localparam logic [3:0] OFS_INSN   = 4'h5;
  localparam logic [3:0] OFS_STATUS = 4'h6;

  // Program status word bit positions
  localparam int PSW_COMPARE  = 0;
  localparam int PSW_CARRY    = 1;
  localparam int PSW_Z        = 2;
  localparam int PSW_BCD      = 3;
  localparam int PSW_INDEX_EN = 4;
  localparam int PSW_W        = 5;

  // Pointer register fields
  localparam int RP_ROW_LO = 0;
  localparam int RP_BANK   = 3;
  localparam int DM_BANK   = 4;

  // Instruction fields
  localparam int INS_OP_LO  = 11;
  localparam int INS_ROW_LO = 8;
  localparam int INS_COL_LO = 4;

  // Status register fields
  localparam int ST_ILLEGAL = 4;
  localparam int ST_CMPOP   = 5;

  localparam logic [4:0] OP_SUB_IMM  = 5'h11;
  localparam logic [4:0] OP_BORROW_REG = 5'h03;
  localparam logic [4:0] OP_BORROW_IMM = 5'h13;

  localparam logic [PSW_W-1:0] PSW_RST  = 5'h00;
  localparam logic [6:0]       INDEX_RST = 7'h00;
  localparam logic [4:0]       RPTR_RST = 5'h00;
  localparam logic [7:0]       MADDR_RST = 8'h00;
  localparam logic [3:0]       NIB_RST  = 4'h0;
  localparam logic [3:0]       BCD_ADJ  = 4'hA;

endpackage

// *** inc/nsu_alu_if.sv ***
// Purpose: Operand and result bundle between sequencer and subtractor.
// Assumes: Purely combinational path.
// Notes:   None.
`timescale 1ns/10ps
interface nsu_alu_if;
  logic [3:0] minuend;
  logic [3:0] subtrahend;
  logic       borrow_in;
  logic       bcd_mode;
  logic [3:0] diff;
  logic       borrow_out;

  modport user (output minuend, subtrahend, borrow_in, bcd_mode,
                input  diff, borrow_out);
  modport alu  (input  minuend, subtrahend, borrow_in, bcd_mode,
                output diff, borrow_out);
endinterface

// *** verilog/nsu_alu.sv ***
// Purpose: Four-bit subtractor, binary or decimal.
// Assumes: Decimal operands are valid digits 0 to 9.
// Notes:   Invalid digits in decimal mode give unspecified results.
`timescale 1ns/10ps
module nsu_alu (
  nsu_alu_if.alu bus
);
  wire [4:0] raw_diff;
  wire       raw_borrow;
  wire [3:0] adj_diff;

  assign raw_diff   = {1'b0, bus.minuend} - {1'b0, bus.subtrahend} - {4'h0, bus.borrow_in};
  assign raw_borrow = raw_diff[4];
  // A decimal borrow wraps through ten instead of sixteen
  assign adj_diff   = raw_diff[3:0] + nsu_pkg::BCD_ADJ;
  assign bus.diff       = (bus.bcd_mode && raw_borrow) ? adj_diff : raw_diff[3:0];
  assign bus.borrow_out = raw_borrow;
  // No clock reaches this block, so its checks sit in the sequencer
endmodule

// *** verilog/nsu_top.sv ***
// Purpose: Nibble subtract unit with its data memory and status word.
// Assumes: Register master never issues read and write together.
// Notes:   An instruction runs in the cycle its word is written.
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
module nsu_top (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata
);

  logic [nsu_pkg::PSW_W-1:0] program_status_word_r;
  logic [6:0]                index_register_r;
  logic [4:0]                rptr_r;
  logic [7:0]                maddr_r;
  logic [3:0]                mem_r [nsu_pkg::MEM_DEPTH];
  logic [5:0]                status_r;
  logic [5:0]                status_nxt;
  logic [15:0]               rdata_nxt;
  logic [nsu_pkg::PSW_W-1:0] psw_nxt;

  nsu_alu_if alu_bus ();

  nsu_alu u_nsu_alu (
    .bus (alu_bus)
  );

  // Register decode
  wire psw_wr   = reg_wr && (reg_addr == nsu_pkg::OFS_PSW);
  wire index_wr = reg_wr && (reg_addr == nsu_pkg::OFS_INDEX);
  wire rptr_wr  = reg_wr && (reg_addr == nsu_pkg::OFS_RPTR);
  wire maddr_wr = reg_wr && (reg_addr == nsu_pkg::OFS_MADDR);
  wire mdata_wr = reg_wr && (reg_addr == nsu_pkg::OFS_MDATA);
  wire exec     = reg_wr && (reg_addr == nsu_pkg::OFS_INSN);

  // Instruction fields
  wire [4:0] opcode    = reg_wdata[15:nsu_pkg::INS_OP_LO];
  wire [2:0] ins_row   = reg_wdata[nsu_pkg::INS_OP_LO-1:nsu_pkg::INS_ROW_LO];
  wire [3:0] ins_col   = reg_wdata[nsu_pkg::INS_ROW_LO-1:nsu_pkg::INS_COL_LO];
  wire [3:0] ins_nib   = reg_wdata[nsu_pkg::INS_COL_LO-1:0];

  wire is_sub_imm  = (opcode == nsu_pkg::OP_SUB_IMM);
  wire is_borrow_reg = (opcode == nsu_pkg::OP_BORROW_REG);
  wire is_borrow_imm = (opcode == nsu_pkg::OP_BORROW_IMM);
  wire legal         = is_sub_imm || is_borrow_reg || is_borrow_imm;
  wire run         = exec && legal;

  // Flag views
  wire compare_flag      = program_status_word_r[nsu_pkg::PSW_COMPARE];
  wire carry_flag        = program_status_word_r[nsu_pkg::PSW_CARRY];
  wire zero_flag         = program_status_word_r[nsu_pkg::PSW_Z];
  wire bcd_flag          = program_status_word_r[nsu_pkg::PSW_BCD];
  wire index_enable_flag = program_status_word_r[nsu_pkg::PSW_INDEX_EN];

  // Effective addresses
  wire [6:0] ins_addr = {ins_row, ins_col};
  wire [6:0] idx_addr = index_enable_flag ? (ins_addr | index_register_r) : ins_addr;
  wire [7:0] mem_ea   = {rptr_r[nsu_pkg::DM_BANK], idx_addr};
  wire [7:0] reg_ea   = {rptr_r[nsu_pkg::RP_BANK], rptr_r[nsu_pkg::RP_BANK-1:nsu_pkg::RP_ROW_LO],
                         ins_nib};
  wire [7:0] dst_ea   = is_borrow_reg ? reg_ea : mem_ea;

  wire [3:0] mem_val  = mem_r[mem_ea];
  wire [3:0] reg_val  = mem_r[reg_ea];

  // Operand steering
  assign alu_bus.minuend    = is_borrow_reg ? reg_val : mem_val;
  assign alu_bus.subtrahend = is_borrow_reg ? mem_val : ins_nib;
  assign alu_bus.borrow_in  = is_sub_imm ? 1'b0 : carry_flag;
  assign alu_bus.bcd_mode   = bcd_flag;

  wire [3:0] result     = alu_bus.diff;
  wire       res_zero   = (result == 4'h0);
  // Compare mode only looks, it never writes the destination
  wire       store      = run && !compare_flag;

  // Zero accumulates across compares so multi-nibble equality works
  wire zero_upd = !res_zero ? 1'b0 : (compare_flag ? zero_flag : 1'b1);

  always_comb begin
    psw_nxt = program_status_word_r;
    if (psw_wr) begin
      psw_nxt = reg_wdata[nsu_pkg::PSW_W-1:0];
    end else if (run) begin
      psw_nxt[nsu_pkg::PSW_CARRY] = alu_bus.borrow_out;
      psw_nxt[nsu_pkg::PSW_Z]  = zero_upd;
    end
  end

  always_comb begin
    status_nxt = status_r;
    if (exec) begin
      status_nxt = {compare_flag, !legal, legal ? result : status_r[3:0]};
    end
  end

  // Memory, one flip-flop nibble per entry
  generate
    for (genvar i = 0; i < nsu_pkg::MEM_DEPTH; i++) begin : g_mem
      wire sw_hit  = mdata_wr && (maddr_r == 8'(i));
      wire op_hit  = store && (dst_ea == 8'(i));
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          mem_r[i] <= nsu_pkg::NIB_RST;
        end else if (sw_hit) begin
          mem_r[i] <= reg_wdata[3:0];
        end else if (op_hit) begin
          mem_r[i] <= result;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      program_status_word_r <= nsu_pkg::PSW_RST;
      status_r              <= 6'h00;
    end else begin
      program_status_word_r <= psw_nxt;
      status_r              <= status_nxt;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      index_register_r <= nsu_pkg::INDEX_RST;
      rptr_r           <= nsu_pkg::RPTR_RST;
      maddr_r          <= nsu_pkg::MADDR_RST;
    end else begin
      if (index_wr) index_register_r <= reg_wdata[6:0];
      if (rptr_wr)  rptr_r <= reg_wdata[4:0];
      if (maddr_wr) maddr_r <= reg_wdata[7:0];
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        nsu_pkg::OFS_PSW:    rdata_nxt = {11'h000, program_status_word_r};
        nsu_pkg::OFS_INDEX:  rdata_nxt = {9'h000, index_register_r};
        nsu_pkg::OFS_RPTR:   rdata_nxt = {11'h000, rptr_r};
        nsu_pkg::OFS_MADDR:  rdata_nxt = {8'h00, maddr_r};
        nsu_pkg::OFS_MDATA:  rdata_nxt = {12'h000, mem_r[maddr_r]};
        nsu_pkg::OFS_STATUS: rdata_nxt = {10'h000, status_r};
        default:             rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  imm_sub_store_a: assert property (
    exec && is_sub_imm && !compare_flag && !bcd_flag
    |=> mem_r[$past(mem_ea)] == 4'($past(mem_val) - $past(ins_nib)))
    else $error("immediate subtract result not stored");

  reg_borrow_store_a: assert property (
    exec && is_borrow_reg && !compare_flag && !bcd_flag
    |=> mem_r[$past(reg_ea)] ==
        4'($past(reg_val) - $past(mem_val) - {3'h0, $past(carry_flag)}))
    else $error("register borrow subtract wrong");

  imm_borrow_store_a: assert property (
    exec && is_borrow_imm && !compare_flag && !bcd_flag
    |=> mem_r[$past(mem_ea)] ==
        4'($past(mem_val) - $past(ins_nib) - {3'h0, $past(carry_flag)}))
    else $error("immediate borrow subtract wrong");

  compare_keep_a: assert property (
    run && compare_flag |=> mem_r[$past(dst_ea)] == $past(mem_r[dst_ea]))
    else $error("compare changed destination");

  carry_borrow_a: assert property (
    run && is_borrow_imm
    |=> carry_flag == ({1'b0, $past(mem_val)} <
                       {1'b0, $past(ins_nib)} + {4'h0, $past(carry_flag)}))
    else $error("carry does not match borrow");

  zero_clear_a: assert property (
    run && !res_zero |=> !zero_flag)
    else $error("zero flag left set on nonzero result");

  zero_set_a: assert property (
    run && res_zero && !compare_flag |=> zero_flag)
    else $error("zero flag not set");

  zero_hold_a: assert property (
    run && res_zero && compare_flag |=> $stable(zero_flag))
    else $error("zero flag changed in compare");

  bcd_wrap_chk_a: assert property (
    run && is_sub_imm && bcd_flag && !compare_flag && (mem_val < ins_nib)
    |=> mem_r[$past(mem_ea)] == 4'($past(mem_val) + 4'hA - $past(ins_nib)))
    else $error("decimal adjust wrong");

  bcd_plain_a: assert property (
    run && is_sub_imm && bcd_flag && !compare_flag && (mem_val >= ins_nib)
    |=> mem_r[$past(mem_ea)] == 4'($past(mem_val) - $past(ins_nib)))
    else $error("decimal subtract without borrow wrong");

  index_or_a: assert property (
    store && index_enable_flag && is_sub_imm && !bcd_flag
    |=> mem_r[{$past(rptr_r[nsu_pkg::DM_BANK]), $past(ins_addr | index_register_r)}] ==
        4'($past(mem_val) - $past(ins_nib)))
    else $error("indexed address not used");

  first_sub_a: assert property (
    run && is_sub_imm && !bcd_flag
    |=> carry_flag == ($past(mem_val) < $past(ins_nib)))
    else $error("plain subtract used old carry");

endmodule

// *** tb/nsu_tb_top.sv ***
// Purpose: Self-checking bench for the nibble subtract unit.
// Assumes: Register port of the top module; one strobe per access.
// Notes:   Each access ends with a spare cycle so no strobe is assigned twice at one edge.
`timescale 1ns/10ps
module nsu_tb_top;
  logic        clock;
  logic        sys_rst;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;

  nsu_top u_nsu_top (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task end_sim;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Run needs under two hundred cycles; the ceiling only catches a hang
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      end_sim;
    end
  end

  function automatic logic [15:0] ins(input logic [4:0] op, input logic [2:0] row,
                                      input logic [3:0] col, input logic [3:0] n);
    return {op, row, col, n};
  endfunction

  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  task wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  // Read data stand only in the cycle after the strobe, so sample just after that edge
  task rdchk(input string name, input logic [3:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(name, exp, reg_rdata);
    @(posedge clock);
  endtask

  task mset(input logic [7:0] a, input logic [3:0] v);
    wr(nsu_pkg::OFS_MADDR, {8'h00, a});
    wr(nsu_pkg::OFS_MDATA, {12'h000, v});
  endtask

  task mchk(input logic [7:0] a, input logic [3:0] exp);
    wr(nsu_pkg::OFS_MADDR, {8'h00, a});
    rdchk("memory nibble", nsu_pkg::OFS_MDATA, {12'h000, exp});
  endtask

  task pchk(input logic [15:0] exp);
    rdchk("status word", nsu_pkg::OFS_PSW, exp);
  endtask

  task t_sub_imm;
    wr(nsu_pkg::OFS_PSW, 16'h0000);
    mset(8'h2F, 4'h3);
    wr(nsu_pkg::OFS_INSN, ins(nsu_pkg::OP_SUB_IMM, 3'h2, 4'hF, 4'h5));
    mchk(8'h2F, 4'hE);
    pchk(16'h0002);
    mset(8'h2F, 4'h5);
    wr(nsu_pkg::OFS_INSN, ins(nsu_pkg::OP_SUB_IMM, 3'h2, 4'hF, 4'h5));
    pchk(16'h0004);
    mchk(8'h2F, 4'h0);
    $display("t_sub_imm done");
  endtask

  // Compare chain: equal nibbles must not set zero, unequal ones must clear it
  task t_compare;
    wr(nsu_pkg::OFS_PSW, 16'h0001);
    mset(8'h30, 4'h5);
    wr(nsu_pkg::OFS_INSN, ins(nsu_pkg::OP_SUB_IMM, 3'h3, 4'h0, 4'h5));
    pchk(16'h0001);
    wr(nsu_pkg::OFS_PSW, 16'h0005);
    wr(nsu_pkg::OFS_INSN, ins(nsu_pkg::OP_SUB_IMM, 3'h3, 4'h0, 4'h5));
    pchk(16'h0005);
    wr(nsu_pkg::OFS_INSN, ins(nsu_pkg::OP_SUB_IMM, 3'h3, 4'h0, 4'h6));
    pchk(16'h0003);
    wr(nsu_pkg::OFS_INSN, ins(nsu_pkg::OP_BORROW_IMM, 3'h3, 4'h0, 4'h4));
    pchk(16'h0001);
    mchk(8'h30, 4'h5);
    $display("t_compare done");
  endtask

  // Three-nibble value 0x300 minus 5 gives 0x2FB through the borrow chain
  task t_chain;
    wr(nsu_pkg::OFS_PSW, 16'h0000);
    mset(8'h0D, 4'h3);
    mset(8'h0E, 4'h0);
    mset(8'h0F, 4'h0);
    wr(nsu_pkg::OFS_INSN, ins(nsu_pkg::OP_SUB_IMM, 3'h0, 4'hF, 4'h5));
    pchk(16'h0002);
    wr(nsu_pkg::OFS_INSN, ins(nsu_pkg::OP_BORROW_IMM, 3'h0, 4'hE, 4'h0));
    wr(nsu_pkg::OFS_INSN, ins(nsu_pkg::OP_BORROW_IMM, 3'h0, 4'hD, 4'h0));
    mchk(8'h0F, 4'hB);
    mchk(8'h0E, 4'hF);
    mchk(8'h0D, 4'h2);
    pchk(16'h0000);
    $display("t_chain done");
  endtask

  task t_reg;
    wr(nsu_pkg::OFS_RPTR, 16'h0001);
    wr(nsu_pkg::OFS_PSW, 16'h0002);
    mset(8'h1A, 4'h7);
    mset(8'h23, 4'h2);
    wr(nsu_pkg::OFS_INSN, ins(nsu_pkg::OP_BORROW_REG, 3'h2, 4'h3, 4'hA));
    mchk(8'h1A, 4'h4);
    mchk(8'h23, 4'h2);
    pchk(16'h0000);
    $display("t_reg done");
  endtask

  task t_bcd_index;
    wr(nsu_pkg::OFS_PSW, 16'h0008);
    mset(8'h40, 4'h3);
    wr(nsu_pkg::OFS_INSN, ins(nsu_pkg::OP_SUB_IMM, 3'h4, 4'h0, 4'h5));
    mchk(8'h40, 4'h8);
    pchk(16'h000A);
    wr(nsu_pkg::OFS_INSN, ins(nsu_pkg::OP_SUB_IMM, 3'h4, 4'h0, 4'h5));
    mchk(8'h40, 4'h3);
    pchk(16'h0008);
    wr(nsu_pkg::OFS_PSW, 16'h0010);
    wr(nsu_pkg::OFS_INDEX, 16'h0040);
    mset(8'h6F, 4'h9);
    mset(8'h2F, 4'h9);
    wr(nsu_pkg::OFS_INSN, ins(nsu_pkg::OP_SUB_IMM, 3'h2, 4'hF, 4'h5));
    mchk(8'h6F, 4'h4);
    mchk(8'h2F, 4'h9);
    rdchk("unmapped word", 4'h9, 16'h0000);
    wr(nsu_pkg::OFS_INSN, 16'h0000);
    pchk(16'h0010);
    // Illegal opcode keeps the last result and raises the illegal bit
    rdchk("status register", nsu_pkg::OFS_STATUS, 16'h0014);
    $display("t_bcd_index done");
  endtask

  initial begin
    sys_rst   = 1'b1;
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_sub_imm;
    t_compare;
    t_chain;
    t_reg;
    t_bcd_index;
    end_sim;
  end
endmodule
